// ===== src/rffct_pkg.sv
// Purpose: Shared constants, field layouts and carriers of the
//          receive-FIFO flow-control trigger.
// Assumes: 10 MHz system clock, 32-bit classic Wishbone register port.
// Notes:   Register offsets are byte addresses of aligned words.
package rffct_pkg;

  // Register map
  localparam int unsigned ADR_W         = 8;
  localparam logic [7:0]  CFG_ADR       = 8'h00;
  localparam logic [7:0]  PAUSE_ADR     = 8'h04;
  localparam logic [7:0]  STAT_ADR      = 8'h08;
  localparam logic [7:0]  CNT_ADR       = 8'h0c;

  // Reset values
  localparam logic [23:0] CFG_RST       = 24'h000000;
  localparam logic [15:0] PAUSE_RST     = 16'h0000;
  localparam logic [15:0] ZERO_QUANTA   = 16'h0000;

  // Levels count in 64-byte units
  localparam int unsigned THR_SHIFT     = 6;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned CYC_PER_US    = 1000 / CLK_PERIOD_NS;
  localparam int unsigned SLOW_EXTRA_NS = 2200;
  localparam int unsigned SLOW_EXTRA_CYC =
    (SLOW_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned JAM_CNT_W     = 16;
  localparam int unsigned JAM_US [16]   = '{5, 10, 15, 25, 50, 100, 150, 200,
                                            250, 300, 350, 400, 450, 500, 550, 600};

  // Configuration word, bits 23:0 of the config register
  typedef struct packed {
    logic [7:0] fifo_high_threshold;
    logic [7:0] fifo_low_threshold;
    logic [3:0] jam_duration_select;
    logic       trigger_on_group_frame;
    logic       trigger_on_broadcast;
    logic       trigger_on_own_address;
    logic       trigger_on_any_frame;
  } rffct_cfg_s;

  // Receive path events, one-cycle pulses
  typedef struct packed {
    logic frame_start;
    logic da_valid;
    logic broadcast;
    logic own_address;
    logic group_frame;
  } rffct_rx_s;

  // Pause request towards the MAC transmitter
  typedef struct packed {
    logic        req;
    logic [15:0] quanta;
  } rffct_pause_s;

  // Status word, bits 5:0 of the status register
  typedef struct packed {
    logic full_duplex;
    logic jamming;
    logic pending;
    logic paused;
    logic below_low;
    logic above_high;
  } rffct_stat_s;

  typedef enum logic {FD_IDLE, FD_PAUSED} rffct_fd_e;

  // Level in 64-byte units to bytes
  function automatic logic [15:0] rffct_thr_bytes(input logic [7:0] lvl);
    rffct_thr_bytes = 16'(lvl) << THR_SHIFT;
  endfunction

endpackage

// ===== src/rffct_jam_timer.sv
// Purpose: Back pressure duration timer; holds busy for the selected time.
// Assumes: start_i is a one-cycle pulse from the same clock domain.
// Notes:   A start while busy reloads the full duration.
`timescale 1ns/100ps
`default_nettype none
module rffct_jam_timer #(
  parameter int unsigned CYC_PER_US = rffct_pkg::CYC_PER_US
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // Control
  input  wire logic       start_i,
  input  wire logic [3:0] code_i,
  input  wire logic       fast_i,
  // Status
  output logic            busy_o
);

  if (CYC_PER_US < 1 || CYC_PER_US * 600 + rffct_pkg::SLOW_EXTRA_CYC > 65535)
  begin : g_bad_rate
    $error("rffct_jam_timer: CYC_PER_US out of range");
  end

  typedef struct packed {
    logic                               busy;
    logic [rffct_pkg::JAM_CNT_W-1:0]    cnt;
  } rffct_jam_s;

  rffct_jam_s s;
  rffct_jam_s next_s;

  // Duration in cycles, longer at the slow link rate
  function automatic logic [rffct_pkg::JAM_CNT_W-1:0] jam_cycles(
    input logic [3:0] code, input logic fast);
    int unsigned c;
    c = rffct_pkg::JAM_US[code] * CYC_PER_US;
    if (!fast)
    begin
      c = c + rffct_pkg::SLOW_EXTRA_CYC;
    end
    jam_cycles = rffct_pkg::JAM_CNT_W'(c);
  endfunction

  // Load on start, count down to zero
  always_comb
  begin
    next_s = s;
    if (start_i)
    begin
      next_s.busy = 1'b1;
      next_s.cnt  = jam_cycles(code_i, fast_i) - 1'b1;
    end
    else if (s.busy)
    begin
      if (s.cnt == '0)
      begin
        next_s.busy = 1'b0;
      end
      else
      begin
        next_s.cnt = s.cnt - 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
    end
    else if (ce_i)
    begin
      s <= next_s;
    end
  end

  assign busy_o = s.busy;

endmodule // rffct_jam_timer
`default_nettype wire

// ===== src/rffct_wb_regs.sv
// Purpose: Classic Wishbone slave holding configuration and pause time.
// Assumes: Single-cycle requests held until ack; 32-bit data.
// Notes:   Ack one cycle after the request; write lands on the acked edge.
`timescale 1ns/100ps
`default_nettype none
module rffct_wb_regs (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        ce_i,
  // Wishbone slave
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [rffct_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  // Block side
  input  wire logic [31:0]                 stat_i,
  input  wire logic [31:0]                 cnt_i,
  output rffct_pkg::rffct_cfg_s            cfg_o,
  output logic      [15:0]                 pause_quanta_o
);

  typedef struct packed {
    logic                  ack;
    logic [31:0]           dat;
    rffct_pkg::rffct_cfg_s cfg;
    logic [15:0]           pause;
  } rffct_regs_s;

  rffct_regs_s s;
  rffct_regs_s next_s;
  logic        req;

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] wr, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[8*i +: 8] = wr[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  assign req = wb_cyc_i && wb_stb_i;

  // Decode, read capture and acked write
  always_comb
  begin
    next_s     = s;
    next_s.ack = req && !s.ack;
    if (req && !s.ack)
    begin
      case (wb_adr_i)
        rffct_pkg::CFG_ADR:   next_s.dat = {8'h00, s.cfg};
        rffct_pkg::PAUSE_ADR: next_s.dat = {16'h0000, s.pause};
        rffct_pkg::STAT_ADR:  next_s.dat = stat_i;
        rffct_pkg::CNT_ADR:   next_s.dat = cnt_i;
        default:              next_s.dat = 32'h00000000;
      endcase
    end
    if (req && s.ack && wb_we_i)
    begin
      case (wb_adr_i)
        rffct_pkg::CFG_ADR:
          next_s.cfg = 24'(merge({8'h00, s.cfg}, wb_dat_i, wb_sel_i));
        rffct_pkg::PAUSE_ADR:
          next_s.pause = 16'(merge({16'h0000, s.pause}, wb_dat_i, wb_sel_i));
        default: ;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s       <= '0;
      s.cfg   <= rffct_pkg::CFG_RST;
      s.pause <= rffct_pkg::PAUSE_RST;
    end
    else if (ce_i)
    begin
      s <= next_s;
    end
  end

  assign wb_ack_o       = s.ack;
  assign wb_dat_o       = s.dat;
  assign cfg_o          = s.cfg;
  assign pause_quanta_o = s.pause;

endmodule // rffct_wb_regs
`default_nettype wire

// ===== src/rffct_trigger.sv
// Purpose: Automatic flow-control trigger on receive FIFO fill level.
// Assumes: Receive events, fill level, duplex and speed come from logic
//          on the same clock; the MAC acknowledges a pause request.
// Notes:   Back pressure in half duplex, pause frames in full duplex.
//
// How it works
// RL1 - Broadcast trigger plus level reached: jam on a broadcast frame.
// RL2 - Own-address trigger plus level reached: jam on a frame for us.
// RL3 - Frame-class trigger bits do nothing in full duplex.
// RL4 - Any-frame trigger: jam in half duplex, pause frame in full duplex.
// RL5 - Full-duplex flow control runs only with the any-frame trigger set.
// RL6 - Half duplex any-frame: act at next preamble, no address decoding.
// RL7 - Full duplex any-frame: request pause the moment level is reached.
// RL8 - Pause request stays pending until the MAC takes it.
// RL9 - Any-frame trigger overrides the three frame-class trigger bits.
// RL10 - High level in 64-byte units; one pause frame per crossing.
// RL11 - After a pause, send zero pause time once below low level.
// RL12 - Jam length from a 4-bit code, 5 us to 600 us, longer at 10M.
// RL13 - Group-frame trigger plus level reached: jam on a multicast frame.
// RL14 - Level comparison re-evaluated every clock cycle.
`timescale 1ns/100ps
`default_nettype none
module rffct_trigger #(
  parameter int unsigned FILL_W     = 16,
  parameter int unsigned CYC_PER_US = rffct_pkg::CYC_PER_US
) (
  // Clock, reset, enable
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        ce_i,
  // Wishbone slave
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [rffct_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  // Receive path
  input  wire rffct_pkg::rffct_rx_s        rx_i,
  input  wire logic [FILL_W-1:0]           fifo_fill_i,
  input  wire logic                        full_duplex_i,
  input  wire logic                        speed_100_i,
  // MAC transmitter
  output rffct_pkg::rffct_pause_s          pause_o,
  input  wire logic                        pause_ack_i,
  output logic                             back_pressure_o
);

  if (FILL_W < 1 || FILL_W > 16)
  begin : g_bad_fill
    $error("rffct_trigger: FILL_W must be 1 to 16");
  end

  typedef struct packed {
    rffct_pkg::rffct_fd_e fd;
    logic                 pend;
    logic [15:0]          quanta;
    logic                 above_high;
    logic                 below_low;
    logic [7:0]           pause_cnt;
    logic [7:0]           zero_cnt;
    logic [7:0]           jam_cnt;
  } rffct_top_s;

  rffct_top_s            s;
  rffct_top_s            next_s;
  rffct_pkg::rffct_cfg_s cfg;
  rffct_pkg::rffct_stat_s stat;
  logic [15:0]           pause_quanta;
  logic [15:0]           fill;
  logic                  above_high;
  logic                  below_low;
  logic                  half;
  logic                  class_hit;
  logic                  jam_start;
  logic                  jam_busy;
  logic                  send_pause;
  logic                  send_zero;

  // Register port
  rffct_wb_regs u_regs (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .ce_i           (ce_i),
    .wb_cyc_i       (wb_cyc_i),
    .wb_stb_i       (wb_stb_i),
    .wb_we_i        (wb_we_i),
    .wb_adr_i       (wb_adr_i),
    .wb_sel_i       (wb_sel_i),
    .wb_dat_i       (wb_dat_i),
    .wb_dat_o       (wb_dat_o),
    .wb_ack_o       (wb_ack_o),
    .stat_i         (32'(stat)),
    .cnt_i          ({8'h00, s.jam_cnt, s.zero_cnt, s.pause_cnt}),
    .cfg_o          (cfg),
    .pause_quanta_o (pause_quanta)
  );

  // Fill at or above a level given in 64-byte units
  function automatic logic level_reached(input logic [15:0] bytes, input logic [7:0] lvl);
    level_reached = bytes >= rffct_pkg::rffct_thr_bytes(lvl);
  endfunction

  // Level comparison on the live fill, every cycle
  assign fill       = 16'(fifo_fill_i);
  assign above_high = level_reached(fill, cfg.fifo_high_threshold);  // see RL10, see RL14
  assign below_low  = !level_reached(fill, cfg.fifo_low_threshold); // see RL11, see RL14
  assign half       = !full_duplex_i;

  // Frame-class match, used only without the any-frame trigger
  always_comb
  begin
    class_hit = 1'b0;
    if (rx_i.da_valid)
    begin
      class_hit = (cfg.trigger_on_broadcast   && rx_i.broadcast)    // see RL1
               || (cfg.trigger_on_own_address && rx_i.own_address)  // see RL2
               || (cfg.trigger_on_group_frame && rx_i.group_frame); // see RL13
    end
  end

  // Half-duplex jam start
  always_comb
  begin
    jam_start = 1'b0;
    if (half && above_high)
    begin
      if (cfg.trigger_on_any_frame)
      begin
        jam_start = rx_i.frame_start; // see RL4, see RL6, see RL9
      end
      else
      begin
        jam_start = class_hit; // see RL1, see RL2, see RL13
      end
    end
  end

  // Back pressure duration timer
  rffct_jam_timer #(
    .CYC_PER_US (CYC_PER_US)
  ) u_jam (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .start_i (jam_start),
    .code_i  (cfg.jam_duration_select), // see RL12
    .fast_i  (speed_100_i),             // see RL12
    .busy_o  (jam_busy)
  );

  // Full-duplex pause decisions; class bits play no part here
  always_comb
  begin
    send_pause = 1'b0;
    send_zero  = 1'b0;
    case (s.fd)
      rffct_pkg::FD_IDLE:
      begin
        // Only the any-frame trigger arms full-duplex control
        send_pause = full_duplex_i && cfg.trigger_on_any_frame
                  && above_high; // see RL3, see RL4, see RL5, see RL7
      end
      rffct_pkg::FD_PAUSED:
      begin
        // Release once drained, or when control is switched off
        send_zero = full_duplex_i
                 && (below_low || !cfg.trigger_on_any_frame); // see RL11
      end
      default:
      begin
        send_pause = 1'b0;
        send_zero  = 1'b0;
      end
    endcase
  end

  // Pause state, pending request and event counters
  always_comb
  begin
    next_s            = s;
    next_s.above_high = above_high;
    next_s.below_low  = below_low;
    // MAC took the request; a new one in the same cycle wins below
    if (pause_ack_i && s.pend)
    begin
      next_s.pend = 1'b0; // see RL8
    end
    case (s.fd)
      rffct_pkg::FD_IDLE:
      begin
        if (send_pause)
        begin
          next_s.fd        = rffct_pkg::FD_PAUSED; // see RL10
          next_s.pend      = 1'b1;                 // see RL7
          next_s.quanta    = pause_quanta;         // see RL10
          next_s.pause_cnt = s.pause_cnt + 8'h01;
        end
      end
      rffct_pkg::FD_PAUSED:
      begin
        if (send_zero)
        begin
          next_s.fd       = rffct_pkg::FD_IDLE;
          next_s.pend     = 1'b1;                  // see RL11
          next_s.quanta   = rffct_pkg::ZERO_QUANTA; // see RL11
          next_s.zero_cnt = s.zero_cnt + 8'h01;
        end
        else if (half)
        begin
          // Link dropped to half duplex: pause no longer meaningful
          next_s.fd = rffct_pkg::FD_IDLE; // see RL3
        end
      end
      default:
      begin
        next_s.fd = rffct_pkg::FD_IDLE;
      end
    endcase
    if (jam_start)
    begin
      next_s.jam_cnt = s.jam_cnt + 8'h01;
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s    <= '0;
      s.fd <= rffct_pkg::FD_IDLE;
    end
    else if (ce_i)
    begin
      s <= next_s;
    end
  end

  // Status word read over the bus
  always_comb
  begin
    stat             = '0;
    stat.above_high  = s.above_high;
    stat.below_low   = s.below_low;
    stat.paused      = (s.fd == rffct_pkg::FD_PAUSED);
    stat.pending     = s.pend;
    stat.jamming     = jam_busy;
    stat.full_duplex = full_duplex_i;
  end

  // Outputs, all from flip-flops
  assign pause_o.req     = s.pend;   // see RL8
  assign pause_o.quanta  = s.quanta;
  assign back_pressure_o = jam_busy; // see RL12

endmodule // rffct_trigger
`default_nettype wire

// ===== testbench/rffct_trigger_monitor.sv
// Purpose: Port checker for the flow-control trigger.
// Assumes: ce_i held high; config shadowed from acked writes.
// Notes:   Bound onto every trigger instance.
`timescale 1ns/100ps
`default_nettype none
module rffct_trigger_monitor #(
  parameter int unsigned FILL_W = 16
) (
  // Clock and reset
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  // Wishbone
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_we_i,
  input wire logic [7:0]              wb_adr_i,
  input wire logic [3:0]              wb_sel_i,
  input wire logic [31:0]             wb_dat_i,
  input wire logic                    wb_ack_o,
  // Receive path and MAC
  input wire rffct_pkg::rffct_rx_s    rx_i,
  input wire logic [FILL_W-1:0]       fifo_fill_i,
  input wire logic                    full_duplex_i,
  input wire rffct_pkg::rffct_pause_s pause_o,
  input wire logic                    pause_ack_i,
  input wire logic                    back_pressure_o
);
  rffct_pkg::rffct_cfg_s cfg;
  logic                  reached;
  logic                  below;
  logic                  bp_cause;

  // Config shadow, loaded on the acked edge of a write
  always_ff @(posedge clk_i)
    if (rst_i)
      cfg <= '0;
    else if (wb_ack_o && wb_cyc_i && wb_we_i && wb_adr_i == rffct_pkg::CFG_ADR)
      for (int b = 0; b < 3; b++)
        if (wb_sel_i[b])
          cfg[8*b +: 8] <= wb_dat_i[8*b +: 8];

  // Level compares and the jam cause
  assign reached = 32'(fifo_fill_i) >= (32'(cfg.fifo_high_threshold) << 6);
  assign below = 32'(fifo_fill_i) < (32'(cfg.fifo_low_threshold) << 6);
  assign bp_cause = !full_duplex_i && reached && (cfg.trigger_on_any_frame ? rx_i.frame_start
    : rx_i.da_valid && (rx_i.broadcast && cfg.trigger_on_broadcast
    || rx_i.own_address && cfg.trigger_on_own_address
    || rx_i.group_frame && cfg.trigger_on_group_frame));

  default clocking mon_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Bus request; full-duplex rise from below low level to the high level
  sequence s_wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_fd_cross;
    full_duplex_i && cfg.trigger_on_any_frame && below
    ##1 full_duplex_i && cfg.trigger_on_any_frame && reached;
  endsequence

  chk_wb_answer: assert property (s_wb_req |=> wb_ack_o)
    else $error("ack late");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_bp_start: assert property (bp_cause |=> back_pressure_o)
    else $error("jam missing");
  chk_bp_cause: assert property ($rose(back_pressure_o) |-> $past(bp_cause))
    else $error("jam without cause");
  chk_pause_now: assert property (s_fd_cross |=> pause_o.req)
    else $error("pause late");
  chk_pause_cause: assert property ($rose(pause_o.req) && pause_o.quanta != 16'h0000
    |-> $past(full_duplex_i && cfg.trigger_on_any_frame && reached))
    else $error("pause without cause");
  chk_pause_hold: assert property (pause_o.req && !pause_ack_i |=> pause_o.req)
    else $error("pause dropped");
  chk_zero_cause: assert property ($rose(pause_o.req) && pause_o.quanta == 16'h0000
    |-> $past(below || !cfg.trigger_on_any_frame))
    else $error("zero pause without cause");
endmodule // rffct_trigger_monitor

bind rffct_trigger rffct_trigger_monitor #(.FILL_W(FILL_W)) u_monitor (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .rx_i(rx_i), .fifo_fill_i(fifo_fill_i),
  .full_duplex_i(full_duplex_i), .pause_o(pause_o), .pause_ack_i(pause_ack_i),
  .back_pressure_o(back_pressure_o));
`default_nettype wire

// ===== testbench/rffct_mac_model.sv
// Purpose: Pause-taking side of the MAC transmitter.
// Assumes: A request is held until acknowledged.
// Notes:   delay_i models a frame in progress before the window.
`timescale 1ns/100ps
`default_nettype none
module rffct_mac_model (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // Pause link
  input  wire rffct_pkg::rffct_pause_s pause_i,
  input  wire logic [3:0]              delay_i,
  output logic                         pause_ack_o
);
  logic [3:0] wait_q;

  // Waits for the next window, then takes the pending pause once
  always_ff @(posedge clk_i)
  begin
    if (rst_i || pause_ack_o || !pause_i.req)
    begin
      pause_ack_o <= 1'b0;
      wait_q      <= 4'h0;
    end
    else if (wait_q >= delay_i)
      pause_ack_o <= 1'b1;
    else
      wait_q <= wait_q + 4'h1;
  end
endmodule // rffct_mac_model
`default_nettype wire

// ===== testbench/tb_top.sv
// Purpose: Self-checking bench for the flow-control trigger.
// Assumes: 10 MHz clock, clock enable held high.
// Notes:   Drivers queue expectations; a watcher compares results.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int unsigned CYC = 10;

  logic                    clk_i = 1'b0;
  logic                    rst_i = 1'b1;
  logic                    wb_cyc_i = 1'b0;
  logic                    wb_stb_i = 1'b0;
  logic                    wb_we_i = 1'b0;
  logic [7:0]              wb_adr_i = 8'h00;
  logic [3:0]              wb_sel_i = 4'h0;
  logic [31:0]             wb_dat_i = 32'h0;
  logic [31:0]             wb_dat_o;
  logic                    wb_ack_o;
  rffct_pkg::rffct_rx_s    rx_i = '0;
  logic [15:0]             fifo_fill_i = 16'h0;
  logic                    full_duplex_i = 1'b0;
  logic                    speed_100_i = 1'b1;
  rffct_pkg::rffct_pause_s pause_o;
  logic                    pause_ack_i;
  logic                    back_pressure_o;
  logic [3:0]              mac_delay = 4'h0;
  logic                    req_prev = 1'b0;
  int                      jam_len = 0;
  int                      fails = 0;
  int                      n_compared = 0;
  logic [31:0]             rd_q[$];
  logic [15:0]             pq[$];
  int                      jq[$];
  logic [11:0]             rows[8] = '{12'h88c, 12'h84a, 12'h909, 12'h08a,
                                       12'h3cc, 12'h5cc, 12'h1ec, 12'h9f0};

  // 100 ns clock
  always #50 clk_i = ~clk_i;

  rffct_trigger #(.FILL_W(16), .CYC_PER_US(CYC)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_i(rx_i),
    .fifo_fill_i(fifo_fill_i), .full_duplex_i(full_duplex_i), .speed_100_i(speed_100_i),
    .pause_o(pause_o), .pause_ack_i(pause_ack_i), .back_pressure_o(back_pressure_o));

  rffct_mac_model mac (
    .clk_i(clk_i), .rst_i(rst_i), .pause_i(pause_o), .delay_i(mac_delay),
    .pause_ack_o(pause_ack_i));

  // Verdict and end of run
  task automatic complete_run();
    if (fails == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Compare one value
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One classic cycle, held until the ack edge
  task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                    input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= d;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1)
        break;
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n == 20)
    begin
      fails++;
      complete_run();
    end
  endtask

  // Read with its expected data noted
  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    rd_q.push_back(exp);
    wb(1'b0, adr, 4'hf, 32'h0);
  endtask

  // One-cycle receive event
  task automatic pulse(input logic [4:0] e);
    @(posedge clk_i);
    rx_i <= e;
    @(posedge clk_i);
    rx_i <= '0;
  endtask

  // Result watcher: read data, jam lengths, pause times
  always @(posedge clk_i)
  begin
    if (wb_ack_o === 1'b1 && !wb_we_i)
      check("read", wb_dat_o, rd_q.size() ? rd_q.pop_front() : 32'hx);
    if (back_pressure_o === 1'b1)
      jam_len++;
    else if (jam_len != 0)
    begin
      check("jam", 32'(jam_len), jq.size() ? 32'(jq.pop_front()) : 32'hx);
      jam_len = 0;
    end
    if (pause_o.req === 1'b1 && !req_prev)
      check("quanta", 32'(pause_o.quanta), pq.size() ? 32'(pq.pop_front()) : 32'hx);
    req_prev = pause_o.req;
  end

  // Main sequence
  initial
  begin
    logic [31:0] v;
    logic [11:0] r;
    logic [15:0] p;
    logic [7:0]  h;
    v = $urandom(32'ha938);
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, byte lanes, an unmapped place
    rd(rffct_pkg::CFG_ADR, 32'h0);
    rd(rffct_pkg::PAUSE_ADR, 32'h0);
    v = $urandom();
    wb(1'b1, rffct_pkg::CFG_ADR, 4'hf, v);
    rd(rffct_pkg::CFG_ADR, v & 32'h00ffffff);
    wb(1'b1, rffct_pkg::CFG_ADR, 4'h2, ~v);
    rd(rffct_pkg::CFG_ADR, {8'h00, v[23:16], ~v[15:8], v[7:0]});
    wb(1'b1, rffct_pkg::PAUSE_ADR, 4'hf, v);
    rd(rffct_pkg::PAUSE_ADR, {16'h0000, v[15:0]});
    wb(1'b1, 8'h10, 4'hf, v);
    rd(8'h10, 32'h0);
    // Every jam code, odd codes at 100M and even codes at 10M, fill exactly at the level
    fifo_fill_i <= 16'h0040;
    for (int c = 0; c < 16; c++)
    begin
      speed_100_i <= c[0];
      wb(1'b1, rffct_pkg::CFG_ADR, 4'hf, 32'h00010001 | 32'(c << 4));
      jq.push_back(rffct_pkg::JAM_US[c]*CYC + (c[0] ? 0 : rffct_pkg::SLOW_EXTRA_CYC));
      pulse(5'h10);
      repeat (jq[0] + 4) @(posedge clk_i);
    end
    // Frame classes, level edge, full duplex and override
    for (int i = 0; i < 8; i++)
    begin
      r = rows[i];
      full_duplex_i <= r[10];
      speed_100_i <= 1'b1;
      fifo_fill_i <= r[9] ? 16'h003f : 16'h0040;
      wb(1'b1, rffct_pkg::CFG_ADR, 4'hf, {28'h0001000, r[8:5]});
      if (r[11])
        jq.push_back(rffct_pkg::JAM_US[0] * CYC);
      pulse(r[4:0]);
      repeat (60) @(posedge clk_i);
    end
    // Pause then release, prompt and slow transmitter
    full_duplex_i <= 1'b0;
    fifo_fill_i <= 16'h0000;
    for (int k = 0; k < 2; k++)
    begin
      v = $urandom();
      p = v[15:0] | 16'h0001;
      h = 8'(v[18:16]) | 8'h02;
      mac_delay <= k ? 4'hc : 4'h0;
      wb(1'b1, rffct_pkg::PAUSE_ADR, 4'hf, {16'h0000, p});
      wb(1'b1, rffct_pkg::CFG_ADR, 4'hf, {8'h00, h, 16'h0101});
      full_duplex_i <= 1'b1;
      pq.push_back(p);
      @(posedge clk_i);
      fifo_fill_i <= (16'(h) << 6) + 16'(v[21:16]);
      repeat (60) @(posedge clk_i);
      pq.push_back(16'h0000);
      fifo_fill_i <= 16'h003f;
      repeat (40) @(posedge clk_i);
    end
    full_duplex_i <= 1'b0;
    rd(rffct_pkg::STAT_ADR, 32'h00000002);
    rd(rffct_pkg::CNT_ADR, 32'h00140202);
    repeat (5) @(posedge clk_i);
    check("left", 32'(jq.size() + pq.size() + rd_q.size()), 32'h0);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
